// ==== hw/servo_status_pkg.sv ====
// Package with constants and types for the servo status output block.
package servo_status_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADDR_ALARM_SRC = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_DEV_WIDTH = 8'h08;
  localparam logic [7:0] ADDR_SPD_WIDTH = 8'h0c;
  localparam logic [7:0] ADDR_POS_ERR = 8'h10;
  localparam logic [7:0] ADDR_SPEED = 8'h14;
  localparam logic [7:0] ADDR_TERM_SEL = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
  // Number of alarm sources and the overload bit among them.
  localparam int NUM_ALARMS = 11;
  localparam int OVERLOAD_BIT = 10;
  localparam logic [10:0] SEVERE_MASK = 11'h7ff;
  // Number of output terminals and width of an assignment code.
  localparam int NUM_TERMS = 4;
  localparam int CODE_W = 5;
  // Assignment codes.
  localparam logic [4:0] CODE_ALARM_NORMAL = 5'h03;
  localparam logic [4:0] CODE_ALARM_INVERT = 5'h04;
  localparam logic [4:0] CODE_DYN_BRAKE = 5'h05;
  localparam logic [4:0] CODE_ZERO_DEV = 5'h08;
  localparam logic [4:0] CODE_ZERO_SPD = 5'h09;
  // Reset values.
  localparam logic [19:0] DEV_WIDTH_RESET = 20'h00190;
  localparam logic [19:0] SPD_WIDTH_RESET = 20'h00000;
  localparam logic [19:0] TERM_SEL_RESET = 20'h00000;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  // Counts per motor revolution of the feedback encoder.
  localparam int COUNTS_PER_REV = 131072;
  // AHB transfer type codes.
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  // Stop sequence states.
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_DECEL = 3'b010,
    ST_COAST = 3'b100
  } stop_state_type;
endpackage

// ==== hw/servo_status_outputs.sv ====
// Alarm latch, dynamic brake, zero-deviation and zero-speed output logic.
//
// Function
// - Any alarm sets and latches alarm flag.
// - Reset rising edge clears alarm once cause gone.
// - Inverted alarm output active while no alarm.
// - Codes 3 and 4 select alarm outputs.
// - Code 5 selects dynamic brake request.
// - Severe alarm holds brake request until reset.
// - Severe alarms other than overload force immediate coasting.
// - Overload decelerates first, coasts when stopped.
// - Zero deviation when error within width.
// - Zero deviation held on outside position mode.
// - Code 8 selects zero deviation flag.
// - Zero speed when speed at most width.
// - Code 9 selects zero speed flag.
// - Deviation counted in encoder feedback counts.
`timescale 1ns/1ps
module servo_status_outputs (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Alarm reset input from the sequence input terminals.
  input wire logic alarm_reset_in,
  // Drive status inputs.
  input wire logic [servo_status_pkg::NUM_ALARMS-1:0] alarm_cause,
  input wire logic position_mode,
  input wire logic motor_stopped,
  input wire logic signed [31:0] position_error,
  input wire logic [31:0] motor_speed,
  // Drive control outputs.
  output logic coast_req,
  output logic decel_req,
  // Assignable sequence output terminals.
  output logic [servo_status_pkg::NUM_TERMS-1:0] term_out,
  // Interrupt.
  output logic irq
);
  import servo_status_pkg::*;

  // Bus and register state.
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;
  logic ctrl_pos_sw, next_ctrl_pos_sw;
  logic [19:0] dev_width, next_dev_width;
  logic [19:0] spd_width, next_spd_width;
  logic [19:0] term_sel, next_term_sel;
  logic [3:0] irq_stat, next_irq_stat;
  logic [3:0] irq_mask, next_irq_mask;
  // Status state.
  logic rst_s1, rst_s2, rst_s3;
  logic alarm_latched, next_alarm_latched;
  logic brake_req, next_brake_req;
  logic zero_dev, next_zero_dev;
  logic zero_spd, next_zero_spd;
  logic [NUM_ALARMS-1:0] alarm_seen, next_alarm_seen;
  stop_state_type stop_state, next_stop_state;
  logic next_coast_req, next_decel_req, next_irq;
  logic [NUM_TERMS-1:0] next_term_out;
  logic rst_edge;
  logic any_alarm;
  logic severe_alarm;
  logic [31:0] err_mag;
  logic addr_phase;
  logic rd_stat;

  // The bus never stalls and never errors.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel && hready && htrans == HTRANS_NONSEQ;
  assign rd_stat = addr_phase && !hwrite && haddr[7:0] == ADDR_IRQ_STAT;

  // Alarm reset is synchronised; the edge detector compares the second and third stages.
  always_ff @(posedge clk) begin
    if (rst) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
      rst_s3 <= 1'b0;
    end else begin
      rst_s1 <= alarm_reset_in;
      rst_s2 <= rst_s1;
      rst_s3 <= rst_s2;
    end
  end
  assign rst_edge = rst_s2 && !rst_s3;

  assign any_alarm = |alarm_cause;
  assign severe_alarm = |(alarm_cause & SEVERE_MASK);
  // Magnitude of the deviation in feedback counts; the error is signed.
  assign err_mag = position_error[31] ? 32'(-position_error)
                                      : 32'(position_error);

  // Next values of the AHB write pipeline, registers and read data.
  always_comb begin
    next_wr_pend = addr_phase && hwrite;
    next_wr_addr = addr_phase ? haddr[7:0] : wr_addr;
    next_ctrl_pos_sw = ctrl_pos_sw;
    next_dev_width = dev_width;
    next_spd_width = spd_width;
    next_term_sel = term_sel;
    next_irq_mask = irq_mask;
    next_hrdata = hrdata;
    if (wr_pend) begin
      case (wr_addr)
        ADDR_CTRL: next_ctrl_pos_sw = hwdata[0];
        ADDR_DEV_WIDTH: next_dev_width = hwdata[19:0];
        ADDR_SPD_WIDTH: next_spd_width = hwdata[19:0];
        ADDR_TERM_SEL: next_term_sel = hwdata[19:0];
        ADDR_IRQ_MASK: next_irq_mask = hwdata[3:0];
        default: next_wr_pend = next_wr_pend;
      endcase
    end
    if (addr_phase && !hwrite) begin
      case (haddr[7:0])
        ADDR_ALARM_SRC: next_hrdata = {21'h0, alarm_seen};
        ADDR_CTRL: next_hrdata = {31'h0, ctrl_pos_sw};
        ADDR_DEV_WIDTH: next_hrdata = {12'h0, dev_width};
        ADDR_SPD_WIDTH: next_hrdata = {12'h0, spd_width};
        ADDR_POS_ERR: next_hrdata = err_mag;
        ADDR_SPEED: next_hrdata = motor_speed;
        ADDR_TERM_SEL: next_hrdata = {12'h0, term_sel};
        ADDR_STATUS: next_hrdata = {25'h0, stop_state, zero_spd,
                                    zero_dev, brake_req, alarm_latched};
        ADDR_IRQ_STAT: next_hrdata = {28'h0, irq_stat};
        ADDR_IRQ_MASK: next_hrdata = {28'h0, irq_mask};
        default: next_hrdata = 32'h0;
      endcase
    end
  end

  // Registers of the bus side.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0;
      ctrl_pos_sw <= CTRL_RESET[0];
      dev_width <= DEV_WIDTH_RESET;
      spd_width <= SPD_WIDTH_RESET;
      term_sel <= TERM_SEL_RESET;
      irq_mask <= 4'h0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      ctrl_pos_sw <= next_ctrl_pos_sw;
      dev_width <= next_dev_width;
      spd_width <= next_spd_width;
      term_sel <= next_term_sel;
      irq_mask <= next_irq_mask;
    end
  end

  // Alarm latch, brake request, flags, stop sequence and interrupts.
  always_comb begin
    next_alarm_latched = alarm_latched;
    next_brake_req = brake_req;
    next_alarm_seen = alarm_seen | alarm_cause;
    if (rst_edge && !any_alarm) begin
      // The cause must be gone, so a reset during an alarm is ignored.
      next_alarm_latched = 1'b0;
      next_brake_req = 1'b0;
      next_alarm_seen = '0;
    end
    if (any_alarm) begin
      next_alarm_latched = 1'b1;
    end
    if (severe_alarm) begin
      next_brake_req = 1'b1;
    end
    // Position mode here means both the drive and software agree on it.
    next_zero_dev = !(position_mode && ctrl_pos_sw) ||
                    err_mag <= {12'h0, dev_width};
    next_zero_spd = motor_speed <= {12'h0, spd_width};
    next_stop_state = stop_state;
    case (stop_state)
      ST_RUN: begin
        if (|(alarm_cause & SEVERE_MASK & ~(11'h1 << OVERLOAD_BIT))) begin
          next_stop_state = ST_COAST;
        end else if (alarm_cause[OVERLOAD_BIT]) begin
          next_stop_state = ST_DECEL;
        end
      end
      ST_DECEL: begin
        if (motor_stopped ||
            |(alarm_cause & SEVERE_MASK & ~(11'h1 << OVERLOAD_BIT))) begin
          next_stop_state = ST_COAST;
        end
      end
      ST_COAST: begin
        if (!next_brake_req) begin
          next_stop_state = ST_RUN;
        end
      end
      default: next_stop_state = ST_RUN;
    endcase
    next_coast_req = next_stop_state == ST_COAST;
    next_decel_req = next_stop_state == ST_DECEL;
    for (int t = 0; t < NUM_TERMS; t++) begin
      case (term_sel[t*CODE_W +: CODE_W])
        CODE_ALARM_NORMAL: next_term_out[t] = next_alarm_latched;
        // Break contact: active while healthy; lets host wait.
        CODE_ALARM_INVERT: next_term_out[t] = !next_alarm_latched;
        CODE_DYN_BRAKE: next_term_out[t] = next_brake_req;
        CODE_ZERO_DEV: next_term_out[t] = next_zero_dev;
        CODE_ZERO_SPD: next_term_out[t] = next_zero_spd;
        default: next_term_out[t] = 1'b0;
      endcase
    end
    // Events: alarm set, brake set, zero deviation rise, zero speed rise.
    // A read clears the status, but a new event in that cycle wins.
    next_irq_stat = rd_stat ? 4'h0 : irq_stat;
    next_irq_stat = next_irq_stat | {next_zero_spd && !zero_spd,
                                     next_zero_dev && !zero_dev,
                                     next_brake_req && !brake_req,
                                     next_alarm_latched && !alarm_latched};
    next_irq = |(next_irq_stat & irq_mask);
  end

  // Registers of the status side.
  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_latched <= 1'b0;
      brake_req <= 1'b0;
      alarm_seen <= '0;
      zero_dev <= 1'b1;
      zero_spd <= 1'b1;
      stop_state <= ST_RUN;
      coast_req <= 1'b0;
      decel_req <= 1'b0;
      term_out <= '0;
      irq_stat <= 4'h0;
      irq <= 1'b0;
    end else begin
      alarm_latched <= next_alarm_latched;
      brake_req <= next_brake_req;
      alarm_seen <= next_alarm_seen;
      zero_dev <= next_zero_dev;
      zero_spd <= next_zero_spd;
      stop_state <= next_stop_state;
      coast_req <= next_coast_req;
      decel_req <= next_decel_req;
      term_out <= next_term_out;
      irq_stat <= next_irq_stat;
      irq <= next_irq;
    end
  end
endmodule

// ==== test/host_term_model.sv ====
// Host controller model reading the inverted alarm terminal.
`timescale 1ns/1ps
module host_term_model #(
  parameter int IGNORE_CYC = 40
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Terminal seen by the host.
  input wire logic inv_alarm,
  output logic alarm_seen
);
  int cnt;
  // The inverted terminal is low after power-up, so it is ignored early.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 0;
      alarm_seen <= 1'b0;
    end else begin
      if (cnt < IGNORE_CYC) cnt <= cnt + 1;
      alarm_seen <= (cnt >= IGNORE_CYC) && !inv_alarm;
    end
  end
endmodule

// ==== test/servo_status_chk.sv ====
// Checker of the stop requests, terminals and bus answer.
`timescale 1ns/1ps
module servo_status_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Inputs watched.
  input wire logic alarm_reset_in,
  input wire logic [servo_status_pkg::NUM_ALARMS-1:0] alarm_cause,
  input wire logic motor_stopped,
  // Outputs watched.
  input wire logic coast_req,
  input wire logic decel_req,
  input wire logic [servo_status_pkg::NUM_TERMS-1:0] term_out,
  input wire logic irq,
  input wire logic hreadyout,
  input wire logic hresp
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Overload braking has two steps: decelerate, then coast once stopped.
  sequence s_stopped;
    decel_req && motor_stopped && !alarm_reset_in;
  endsequence
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("Bus answer not ready or not okay.");
  AST_COAST_SEVERE: assert property (|alarm_cause[9:0] |=> coast_req)
    else $error("Severe alarm did not coast.");
  AST_DECEL_OVERLOAD: assert property (alarm_cause == 11'h400 && !coast_req
    && !decel_req |=> decel_req && !coast_req)
    else $error("Overload did not decelerate first.");
  AST_STOP_COAST: assert property (s_stopped |-> ##[1:2] coast_req)
    else $error("Stopped motor did not coast.");
  // Reset is sampled rising three edges before coast is seen to fall.
  AST_BRAKE_HOLD: assert property ($fell(coast_req) |->
    $past(alarm_reset_in, 3) && !$past(alarm_reset_in, 4))
    else $error("Brake released without reset input.");
  AST_COAST_CAUSE: assert property ($rose(coast_req) |->
    $past(alarm_cause) != 11'h000 || $past(decel_req))
    else $error("Coast without a cause.");
  AST_DECEL_CAUSE: assert property ($rose(decel_req) |->
    $past(alarm_cause) == 11'h400)
    else $error("Deceleration without overload.");
  AST_STOP_EXCL: assert property (!(coast_req && decel_req))
    else $error("Coast and deceleration together.");
  AST_RESET_OUT: assert property (disable iff (1'b0) rst |=> !coast_req
    && !decel_req && !irq && term_out == 4'h0)
    else $error("Outputs not cleared by reset.");
endmodule
bind servo_status_outputs servo_status_chk chk (.clk(clk), .rst(rst),
  .alarm_reset_in(alarm_reset_in), .alarm_cause(alarm_cause),
  .motor_stopped(motor_stopped), .coast_req(coast_req),
  .decel_req(decel_req), .term_out(term_out), .irq(irq),
  .hreadyout(hreadyout), .hresp(hresp));

// ==== test/servo_status_outputs_test.sv ====
// Self-checking testbench of the servo status output block.
`timescale 1ns/1ps
module servo_status_outputs_test;
  import servo_status_pkg::*;
  logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rdat, motor_speed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic alarm_reset_in, position_mode, motor_stopped;
  logic coast_req, decel_req, alarm_seen;
  logic [NUM_ALARMS-1:0] alarm_cause;
  logic signed [31:0] position_error;
  logic [NUM_TERMS-1:0] term_out;
  int fails = 0;
  int compares = 0;
  int errs[4] = '{400, 401, -400, -401};
  int spds[4] = '{0, 1, 5, 6};
  assign hready = hreadyout;
  servo_status_outputs uut (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .alarm_reset_in(alarm_reset_in), .alarm_cause(alarm_cause),
    .position_mode(position_mode), .motor_stopped(motor_stopped),
    .position_error(position_error), .motor_speed(motor_speed),
    .coast_req(coast_req), .decel_req(decel_req),
    .term_out(term_out), .irq(irq));
  host_term_model host (.clk(clk), .rst(rst), .inv_alarm(term_out[1]),
    .alarm_seen(alarm_seen));
  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // One AHB single transfer; read data is taken at the data phase's end.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rdat = hrdata;
  endtask
  // Held two cycles so the clear is not sensitive to the exact latency.
  task pulse_reset;
    alarm_reset_in <= 1'b1;
    cyc(2);
    alarm_reset_in <= 1'b0;
    cyc(4);
  endtask
  task summarize;
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog; the tests need well under a thousand cycles.
  initial begin
    cyc(3000);
    fails++;
    summarize;
  end
  // Main test sequence.
  initial begin
    {rst, position_mode} = 2'b11;
    {hsel, hwrite, alarm_reset_in, motor_stopped} = 4'h0;
    {haddr, hwdata, motor_speed, position_error} = '0;
    {htrans, hsize, alarm_cause} = {2'b00, 3'b010, 11'h000};
    cyc(16);
    rst <= 1'b0;
    cyc(1);
    xfer(0, ADDR_DEV_WIDTH, 0);
    chk("dev_width", 32'h190, rdat);
    xfer(0, 8'h30, 0);
    chk("unmapped", 32'h0, rdat);
    // Terminals are still unassigned and low, so the host must ignore them.
    chk("host early", 0, alarm_seen);
    xfer(1, ADDR_TERM_SEL, 32'h41483);
    xfer(1, ADDR_IRQ_MASK, 32'h1);
    xfer(0, ADDR_IRQ_STAT, 0);
    cyc(50);
    chk("idle terms", 4'b1010, term_out);
    chk("host idle", 0, alarm_seen);
    $display("Test terminals done");
    alarm_cause <= 11'h001;
    cyc(3);
    alarm_cause <= 11'h000;
    cyc(3);
    chk("alarm terms", 4'b1101, term_out);
    chk("host alarm", 1, alarm_seen);
    chk("irq", 1, irq);
    xfer(0, ADDR_IRQ_STAT, 0);
    chk("irq stat", 4'h3, rdat[3:0]);
    xfer(0, ADDR_STATUS, 0);
    chk("status", 32'h4f, rdat);
    xfer(0, ADDR_ALARM_SRC, 0);
    chk("alarm src", 32'h001, rdat);
    cyc(2);
    chk("irq clear", 0, irq);
    alarm_cause <= 11'h001;
    pulse_reset;
    chk("reset w cause", 4'b1101, term_out);
    alarm_cause <= 11'h000;
    pulse_reset;
    chk("reset terms", 4'b1010, term_out);
    chk("coast off", 0, coast_req);
    // A reset input held high must not clear a later one-cycle alarm.
    alarm_reset_in <= 1'b1;
    cyc(4);
    alarm_cause <= 11'h001;
    cyc(1);
    alarm_cause <= 11'h000;
    cyc(4);
    chk("held reset", 4'b1101, term_out);
    alarm_reset_in <= 1'b0;
    cyc(2);
    pulse_reset;
    chk("new edge", 4'b1010, term_out);
    $display("Test alarm done");
    alarm_cause <= 11'h400;
    cyc(3);
    chk("decel", 3'b110, {decel_req, term_out[2], coast_req});
    alarm_cause <= 11'h000;
    motor_stopped <= 1'b1;
    cyc(3);
    chk("coast", 2'b01, {decel_req, coast_req});
    pulse_reset;
    motor_stopped <= 1'b0;
    chk("run", 2'b00, {term_out[2], coast_req});
    $display("Test overload done");
    for (int i = 0; i < 4; i++) begin
      position_error <= errs[i];
      cyc(3);
      chk("zero dev", 32'(i % 2 == 0), term_out[3]);
    end
    xfer(0, ADDR_POS_ERR, 0);
    chk("pos err", 32'd401, rdat);
    // Software switching the comparison off holds the flag on as well.
    xfer(1, ADDR_CTRL, 32'h0);
    cyc(3);
    chk("zero dev ctrl", 1, term_out[3]);
    xfer(1, ADDR_CTRL, 32'h1);
    cyc(3);
    chk("zero dev back", 0, term_out[3]);
    position_mode <= 1'b0;
    cyc(3);
    chk("zero dev mode", 1, term_out[3]);
    xfer(1, ADDR_TERM_SEL, 32'h49483);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) xfer(1, ADDR_SPD_WIDTH, 32'h5);
      motor_speed <= spds[i];
      cyc(3);
      chk("zero speed", 32'(i % 2 == 0), term_out[3]);
    end
    $display("Test zero flags done");
    summarize;
  end
endmodule
